/* File: core/iesev_pkg.sv */
package iesev_pkg;

  // ****************************************************************
  // Register map.
  // ****************************************************************

  // Address width of the register port.
  localparam int ADDR_W = 12;
  // Data width of the register port.
  localparam int DATA_W = 32;
  // Number of error bit positions, reserved bit 3 included.
  localparam int NUM_ERR = 19;

  // Severity select register offset.
  localparam logic [11:0] SEV_OFFSET = 12'h48c;
  // Injection test register offset.
  localparam logic [11:0] TEST_OFFSET = 12'h490;
  // Internal error status offset, write one to clear.
  localparam logic [11:0] STATUS_OFFSET = 12'h494;
  // Internal error mask offset.
  localparam logic [11:0] MASK_OFFSET = 12'h498;
  // Interrupt status offset, read only.
  localparam logic [11:0] IRQ_STAT_OFFSET = 12'h4a0;
  // Interrupt clear offset, write only.
  localparam logic [11:0] IRQ_CLR_OFFSET = 12'h4a4;
  // Interrupt enable offset.
  localparam logic [11:0] IRQ_EN_OFFSET = 12'h4a8;

  // ****************************************************************
  // Field layout and reset values.
  // ****************************************************************

  // Reserved bit inside the defined range.
  localparam int RSVD_BIT = 3;
  // Mask of defined error bits.
  localparam logic [18:0] DEF_MASK = 19'h7fff7;
  // Severity reset: bits 0, 4, 8, 10, 12, 14, 15, 18 uncorrectable.
  localparam logic [18:0] SEV_RESET = 19'h4d511;
  // Test register reads zero.
  localparam logic [31:0] TEST_READ = 32'h0;
  // Status and mask reset values.
  localparam logic [18:0] STATUS_RESET = 19'h0;
  localparam logic [18:0] MASK_RESET = 19'h0;
  // Interrupt bit positions.
  localparam int IRQ_UNCOR_BIT = 0;
  localparam int IRQ_COR_BIT = 1;

  // Register port request.
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } iesev_req_t;

  // Report lines.
  typedef struct packed {
    logic uncor;
    logic cor;
  } iesev_rpt_t;

endpackage

/* File: core/iesev_sticky.sv */
`timescale 1ns/1ps

// ******************************************************************
// Sticky bit vector with set priority over clear.
// ******************************************************************
module iesev_sticky #(
  parameter int WIDTH = 19,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  output logic [WIDTH-1:0] bits_o
);

  // One flop per bit; a set in the clear cycle wins.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
          bits_o[g] <= RESET_VAL[g];
        end else if (set_i[g]) begin
          bits_o[g] <= 1'h1;
        end else if (clr_i[g]) begin
          bits_o[g] <= 1'h0;
        end
      end
    end
  endgenerate

endmodule

/* File: core/iesev_report.sv */
`timescale 1ns/1ps

// ******************************************************************
// Severity steering of unmasked status into two reports.
// ******************************************************************
module iesev_report #(
  parameter int WIDTH = 19
) (
  input wire logic [WIDTH-1:0] status_i,
  input wire logic [WIDTH-1:0] mask_i,
  input wire logic [WIDTH-1:0] sev_i,
  output iesev_pkg::iesev_rpt_t rpt_o
);

  // Unmasked set status bits.
  logic [WIDTH-1:0] live;

  // Severity one goes uncorrectable, zero goes correctable.
  always_comb begin
    live = status_i & ~mask_i;
    rpt_o.uncor = |(live & sev_i);
    rpt_o.cor = |(live & ~sev_i);
  end

endmodule

/* File: core/iesev_top.sv */
// Implementation choice: the strobed register port.
`timescale 1ns/1ps

module iesev_top #(
  parameter int NUM_ERR = 19
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [18:0] err_detect_i,
  output logic [31:0] rdata_o,
  output logic uncor_err_o,
  output logic cor_err_o,
  output logic irq_o
);

  // ****************************************************************
  // Register decode.
  // ****************************************************************

  // Bundled request.
  iesev_pkg::iesev_req_t req;
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // Returns true on a write to the given offset.
  function automatic logic wr_hit(input iesev_pkg::iesev_req_t r,
                                  input logic [11:0] off);
    wr_hit = r.wr && (r.addr == off);
  endfunction

  // Write data limited to defined bits.
  // Bits 31:19 and the reserved bit 3 never reach any register.
  logic [18:0] wbits;
  assign wbits = req.wdata[18:0] & iesev_pkg::DEF_MASK;

  // ****************************************************************
  // Severity and mask registers.
  // ****************************************************************

  // Severity select, software writable.
  logic [18:0] sev;
  // Status mask, software writable.
  logic [18:0] mask;

  // Severity reset picks uncorrectable for the double-bit class.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      sev <= iesev_pkg::SEV_RESET;
    end else if (wr_hit(req, iesev_pkg::SEV_OFFSET)) begin
      sev <= wbits;
    end
  end

  // Mask register update.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      mask <= iesev_pkg::MASK_RESET;
    end else if (wr_hit(req, iesev_pkg::MASK_OFFSET)) begin
      mask <= wbits;
    end
  end

  // ****************************************************************
  // Internal error status.
  // ****************************************************************

  // Status vector.
  logic [18:0] status;
  // Set sources: detection or test injection.
  logic [18:0] st_set;
  // Clear from write one to status.
  logic [18:0] st_clr;

  // Injected bits join detected ones on the same set path.
  // A test write and a detection in one cycle simply merge, so neither
  // can be lost, and the defined-bit mask drops the reserved bit.
  always_comb begin
    st_set = err_detect_i & iesev_pkg::DEF_MASK;
    if (wr_hit(req, iesev_pkg::TEST_OFFSET)) begin
      st_set = st_set | wbits;
    end
    st_clr = wr_hit(req, iesev_pkg::STATUS_OFFSET) ? wbits : 19'h0;
  end

  // Status flops, set over clear.
  iesev_sticky #(
    .WIDTH(NUM_ERR),
    .RESET_VAL(iesev_pkg::STATUS_RESET)
  ) u_status (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .set_i(st_set),
    .clr_i(st_clr),
    .bits_o(status)
  );

  // ****************************************************************
  // Reporting.
  // ****************************************************************

  // Combined reports.
  iesev_pkg::iesev_rpt_t rpt;

  // Severity routing of unmasked status.
  iesev_report #(
    .WIDTH(NUM_ERR)
  ) u_report (
    .status_i(status),
    .mask_i(mask),
    .sev_i(sev),
    .rpt_o(rpt)
  );

  // Registered report outputs.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      uncor_err_o <= 1'h0;
      cor_err_o <= 1'h0;
    end else begin
      uncor_err_o <= rpt.uncor;
      cor_err_o <= rpt.cor;
    end
  end

  // ****************************************************************
  // Interrupt block.
  // ****************************************************************

  // Sticky interrupt status and enable.
  logic [1:0] irq_stat;
  logic [1:0] irq_en;
  // Rising edges of the reports.
  logic [1:0] irq_set;
  logic [1:0] irq_clr;

  // Events are report assertions.
  // A level report would set the flag again right after a clear, so
  // only the rising edge of each report counts as a new event.
  always_comb begin
    irq_set[iesev_pkg::IRQ_UNCOR_BIT] = rpt.uncor & ~uncor_err_o;
    irq_set[iesev_pkg::IRQ_COR_BIT] = rpt.cor & ~cor_err_o;
    irq_clr = wr_hit(req, iesev_pkg::IRQ_CLR_OFFSET) ?
              req.wdata[1:0] : 2'h0;
  end

  // Interrupt status flops.
  iesev_sticky #(
    .WIDTH(2),
    .RESET_VAL(2'h0)
  ) u_irq (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .set_i(irq_set),
    .clr_i(irq_clr),
    .bits_o(irq_stat)
  );

  // Interrupt enable register.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      irq_en <= 2'h0;
    end else if (wr_hit(req, iesev_pkg::IRQ_EN_OFFSET)) begin
      irq_en <= req.wdata[1:0];
    end
  end

  // Level interrupt.
  assign irq_o = |(irq_stat & irq_en);

  // ****************************************************************
  // Read data.
  // ****************************************************************

  // Read mux, registered one cycle after the strobe.
  // Unmapped and write-only offsets read as zero, and the test register
  // never shows what was last written to it.
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      rdata_o <= 32'h0;
    end else if (req.rd) begin
      unique case (req.addr)
        iesev_pkg::SEV_OFFSET: rdata_o <= {13'h0, sev};
        iesev_pkg::TEST_OFFSET: rdata_o <= iesev_pkg::TEST_READ;
        iesev_pkg::STATUS_OFFSET: rdata_o <= {13'h0, status};
        iesev_pkg::MASK_OFFSET: rdata_o <= {13'h0, mask};
        iesev_pkg::IRQ_STAT_OFFSET: rdata_o <= {30'h0, irq_stat};
        iesev_pkg::IRQ_EN_OFFSET: rdata_o <= {30'h0, irq_en};
        default: rdata_o <= 32'h0;
      endcase
    end else begin
      rdata_o <= 32'h0;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************

  // Test write sets the status bit next cycle.
  a_test_sets_status: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    wr_hit(req, iesev_pkg::TEST_OFFSET) |=>
      ((status & $past(wbits)) == $past(wbits)))
    else $error("Test write did not set status.");

  // Test register read returns zero.
  a_test_reads_zero: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (rd_i && addr_i == iesev_pkg::TEST_OFFSET) |=> (rdata_o == 32'h0))
    else $error("Test register read not zero.");

  // Uncorrectable report follows severity-one unmasked status.
  a_uncor_report: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ##1 uncor_err_o == $past(|(status & ~mask & sev)))
    else $error("Uncorrectable report mismatch.");

  // Correctable report follows severity-zero unmasked status.
  a_cor_report: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ##1 cor_err_o == $past(|(status & ~mask & ~sev)))
    else $error("Correctable report mismatch.");

  // Severity reset value after reset release.
  a_sev_reset: assert property (
    @(posedge sys_clk_i)
    !reset_n_i |=> (sev[18] && sev[15] && sev[14] && sev[12]))
    else $error("Severity one bits wrong after reset.");

  // Correctable defaults of bits 13, 16 and 17, and uncorrectable bit 0, after reset.
  a_sev_reset_low: assert property (
    @(posedge sys_clk_i)
    !reset_n_i |=> (!sev[13] && !sev[16] && !sev[17] && sev[0]))
    else $error("Severity zero bits wrong after reset.");

  // Reserved bit 3 never sets from a test write.
  a_rsvd_clear: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ##1 !status[iesev_pkg::RSVD_BIT])
    else $error("Reserved status bit set.");

  // Injected unmasked bit yields a report two cycles later.
  a_inject_report: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (wr_hit(req, iesev_pkg::TEST_OFFSET) && |(wbits & ~mask) &&
     !wr_hit(req, iesev_pkg::MASK_OFFSET)) |->
      ##2 (uncor_err_o || cor_err_o))
    else $error("Injected error not reported.");

  // Writing zeros to the test register leaves the status alone.
  a_zero_keeps_status: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (wr_hit(req, iesev_pkg::TEST_OFFSET) && (wbits == 19'h0) &&
     (err_detect_i == 19'h0)) |=> (status == $past(status)))
    else $error("Zero test write changed status.");

  // The reserved severity bit never holds a one.
  a_sev_rsvd_low: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    ##1 !sev[iesev_pkg::RSVD_BIT])
    else $error("Reserved severity bit set.");

  // Severity reads keep the upper reserved field at zero.
  a_sev_read_upper: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (rd_i && addr_i == iesev_pkg::SEV_OFFSET) |=> (rdata_o[31:19] == 13'h0))
    else $error("Severity reserved field not zero.");

  // Read data drops to zero after a cycle with no read.
  a_rdata_idle: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    !rd_i |=> (rdata_o == 32'h0))
    else $error("Read data not zero after idle cycle.");

  // ****************************************************************
  // Covers.
  // ****************************************************************

  // Scenario covers.
  c_inject: cover property (@(posedge sys_clk_i)
    wr_hit(req, iesev_pkg::TEST_OFFSET));
  c_uncor: cover property (@(posedge sys_clk_i) uncor_err_o);
  c_cor: cover property (@(posedge sys_clk_i) cor_err_o);
  c_irq: cover property (@(posedge sys_clk_i) irq_o);
  c_masked: cover property (@(posedge sys_clk_i) |(status & mask));

endmodule

/* File: verif/internal_error_severity_test_test.sv */
`timescale 1ns/1ps

module internal_error_severity_test_test;

  // ****************************************************************
  // Signals, counters and the queue of expected read data.
  // ****************************************************************

  logic sys_clk = 1'b0;
  logic reset_n, wr, rd, uncor, cor, irq;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, v, r;
  logic [18:0] err_det;
  logic s;
  logic rd_d = 1'b0;
  logic [31:0] exp_q[$];
  int err_total = 0;
  int total_checks = 0;
  int seed = 88;

  iesev_top u_iesev_top (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .err_detect_i(err_det),
    .rdata_o(rdata), .uncor_err_o(uncor), .cor_err_o(cor), .irq_o(irq)
  );

  // Free running 20 MHz clock.
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  // Compares one value and counts it.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and stops the run.
  task automatic end_sim();
    if (err_total == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One bus cycle; the request is taken at the following edge.
  task automatic bus(input logic w, input logic rr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    wr <= w;
    rd <= rr;
    addr <= a;
    wdata <= d;
  endtask

  // Notes the expected data, then issues the read.
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 32'h0);
  endtask

  // Lets the reports settle, then compares them.
  task automatic look(input logic u, input logic c, input logic i);
    repeat (3) bus(1'b0, 1'b0, 12'h000, 32'h0);
    @(negedge sys_clk);
    chk({29'h0, uncor, cor, irq}, {29'h0, u, c, i});
  endtask

  // ****************************************************************
  // Read data monitor.
  // ****************************************************************

  // Remembers that a read was taken at this edge.
  always @(posedge sys_clk) begin
    rd_d <= rd & reset_n;
  end

  // Read data stands one cycle after the read, zero at other times.
  always @(negedge sys_clk) begin
    if (rd_d) begin
      chk(rdata, exp_q.pop_front());
    end else begin
      chk(rdata, 32'h0);
    end
  end

  // Cuts a hang short after far more cycles than the tests need.
  initial begin
    #250000;
    err_total++;
    end_sim();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************

  initial begin
    reset_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 12'h000;
    wdata = 32'h0;
    err_det = 19'h0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    v = {13'h0, iesev_pkg::SEV_RESET};
    rd_chk(iesev_pkg::SEV_OFFSET, v);
    rd_chk(iesev_pkg::TEST_OFFSET, 32'h0);
    rd_chk(12'h000, 32'h0);
    bus(1'b1, 1'b0, iesev_pkg::SEV_OFFSET, 32'hffffffff);
    rd_chk(iesev_pkg::SEV_OFFSET, {13'h0, iesev_pkg::DEF_MASK});
    // Every error bit in both severities, injected by the test register.
    for (int p = 0; p < 2; p++) begin
      v = (p == 0) ? {13'h0, iesev_pkg::SEV_RESET} :
          {13'h0, ~iesev_pkg::SEV_RESET & iesev_pkg::DEF_MASK};
      bus(1'b1, 1'b0, iesev_pkg::SEV_OFFSET, v);
      for (int i = 0; i < 19; i++) begin
        if (i != 3) begin
          v = 32'h1 << i;
          s = iesev_pkg::SEV_RESET[i] ^ p[0];
          bus(1'b1, 1'b0, iesev_pkg::TEST_OFFSET, v);
          bus(1'b1, 1'b0, iesev_pkg::TEST_OFFSET, 32'h0);
          rd_chk(iesev_pkg::STATUS_OFFSET, v);
          rd_chk(iesev_pkg::TEST_OFFSET, 32'h0);
          look(s, ~s, 1'b0);
          bus(1'b1, 1'b0, iesev_pkg::STATUS_OFFSET, v);
        end
      end
    end
    // Random write with bit 3 forced: reserved bits must not set status.
    r = $random(seed) | 32'h8;
    bus(1'b1, 1'b0, iesev_pkg::TEST_OFFSET, r);
    v = r & {13'h0, iesev_pkg::DEF_MASK};
    rd_chk(iesev_pkg::STATUS_OFFSET, v);
    bus(1'b1, 1'b0, iesev_pkg::STATUS_OFFSET, 32'hffffffff);
    // Masked injected error stays silent until unmasked.
    bus(1'b1, 1'b0, iesev_pkg::MASK_OFFSET, {13'h0, iesev_pkg::DEF_MASK});
    rd_chk(iesev_pkg::MASK_OFFSET, {13'h0, iesev_pkg::DEF_MASK});
    bus(1'b1, 1'b0, iesev_pkg::SEV_OFFSET, {13'h0, iesev_pkg::SEV_RESET});
    bus(1'b1, 1'b0, iesev_pkg::TEST_OFFSET, 32'h1000);
    look(1'b0, 1'b0, 1'b0);
    bus(1'b1, 1'b0, iesev_pkg::MASK_OFFSET, 32'h0);
    look(1'b1, 1'b0, 1'b0);
    bus(1'b1, 1'b0, iesev_pkg::STATUS_OFFSET, 32'hffffffff);
    // Detected error raises the interrupt, then enable and clear.
    bus(1'b1, 1'b0, iesev_pkg::IRQ_CLR_OFFSET, 32'h3);
    bus(1'b1, 1'b0, iesev_pkg::IRQ_EN_OFFSET, 32'h3);
    err_det <= 19'h02000;
    bus(1'b0, 1'b0, 12'h000, 32'h0);
    err_det <= 19'h0;
    look(1'b0, 1'b1, 1'b1);
    rd_chk(iesev_pkg::IRQ_STAT_OFFSET, 32'h2);
    bus(1'b1, 1'b0, iesev_pkg::IRQ_EN_OFFSET, 32'h0);
    look(1'b0, 1'b1, 1'b0);
    bus(1'b1, 1'b0, iesev_pkg::IRQ_EN_OFFSET, 32'h3);
    bus(1'b1, 1'b0, iesev_pkg::IRQ_CLR_OFFSET, 32'h2);
    look(1'b0, 1'b1, 1'b0);
    end_sim();
  end

endmodule
